// [hw/hwe_pkg.sv]
/*
 * shared constants for the host wake event register block: offsets,
 * field positions, masks, LPC codes and the LPC target state type.
 * assumes every user refers to names as hwe_pkg::name.
 */
`default_nettype none

package hwe_pkg;
	// plug-and-play identity of the wake controller
	localparam logic [7:0] LDN_WAKE     = 8'h04; // logical device number
	localparam int         ADDR_W       = 16;    // LPC I/O address width
	localparam int         OFS_W        = 5;     // decode window is 32 bytes
	// register offsets from the base
	localparam logic [4:0] OFS_STATUS   = 5'h00; // wake_event_status
	localparam logic [4:0] OFS_ENABLE   = 5'h02; // wake_event_enable
	localparam logic [4:0] OFS_MONITOR  = 5'h06; // wake_signal_monitor
	localparam logic [4:0] OFS_ACPI     = 5'h07; // acpi_state_request
	localparam logic [4:0] OFS_SMI_EN   = 5'h13; // wake_smi_route_enable
	localparam logic [4:0] OFS_IRQ_EN   = 5'h15; // wake_irq_route_enable
	// event bit positions, shared by status, enable and routing registers
	localparam int         BIT_MODULE   = 7;     // module interrupt event
	localparam int         BIT_SW       = 6;     // software event
	localparam int         BIT_PHONE    = 3;     // telephone ring event
	localparam int         BIT_RING2    = 1;     // second modem ring
	localparam int         BIT_RING1    = 0;     // first modem ring
	// monitor bit positions
	localparam int         MON_DRV      = 5;     // wake request we drive
	localparam int         MON_PIN      = 4;     // wake request pin level
	localparam int         MON_PM2      = 3;     // pm channel 2 smi level
	localparam int         MON_PM1      = 2;     // pm channel 1 smi level
	localparam int         MON_CTL_SMI  = 1;     // smi we drive
	localparam int         MON_SMI_PIN  = 0;     // smi pin level
	// writable bits and reset values
	localparam logic [7:0] EVENT_MASK   = 8'hCB; // status/enable bits that exist
	localparam logic [7:0] HW_CLR_MASK  = 8'h8B; // plain write-1-to-clear bits
	localparam logic [7:0] ROUTE_MASK   = 8'hCB; // smi/irq routing bits
	localparam logic [7:0] ACPI_MASK    = 8'h3E; // sleep state request bits
	localparam logic [7:0] REG_RESET    = 8'h00; // reset value of every stored host register
	localparam logic [7:0] READ_ZERO    = 8'h00; // unmapped and write-only reads
	// LPC nibble codes
	localparam logic [3:0] LPC_START    = 4'h0;  // start of a target cycle
	localparam logic [2:0] LPC_IO_RD    = 3'h0;  // cycle type I/O read
	localparam logic [2:0] LPC_IO_WR    = 3'h1;  // cycle type I/O write
	localparam logic [3:0] LPC_SYNC_OK  = 4'h0;  // sync ready
	localparam logic [3:0] LPC_TAR      = 4'hF;  // turnaround drive value
	localparam logic [1:0] ADDR_LAST    = 2'h3;  // fourth address nibble
	localparam logic [1:0] PAIR_LAST    = 2'h1;  // second nibble of a pair

	// LPC target sequencer states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000, // wait for start
		ST_CYC   = 4'b0001, // cycle type and direction
		ST_ADDR  = 4'b0010, // four address nibbles
		ST_WDATA = 4'b0011, // two write data nibbles
		ST_HTAR  = 4'b0100, // host turnaround
		ST_SYNC  = 4'b0101, // our sync nibble
		ST_RDATA = 4'b0110, // two read data nibbles
		ST_DTAR  = 4'b0111, // our turnaround
		ST_SKIP  = 4'b1000  // not ours, wait for next frame
	} hwe_lpc_state_t;
endpackage : hwe_pkg

`default_nettype wire

// [hw/hwe_sync.sv]
/*
 * two flip-flop synchroniser for a group of independent pin levels.
 * assumes each bit is a slow level; no bus coherency is promised.
 */
`default_nettype none

module hwe_sync #(
	parameter int         W       = 1,   // number of levels
	parameter logic [W-1:0] RST_VAL = '1 // idle pin level
) (
	input  wire logic         CLOCK, // block clock
	input  wire logic         NRST,  // synchronous reset, low
	input  wire logic [W-1:0] D,     // asynchronous levels
	output logic      [W-1:0] Q      // synchronised levels
);
	logic [W-1:0] meta_reg; // first stage, read only by Q

	////////////////////////////////////////////////////////////////
	// both stages reset to the idle level so no false edge follows
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			meta_reg <= RST_VAL;
			Q        <= RST_VAL;
		end else begin
			meta_reg <= D;
			Q        <= meta_reg;
		end
	end
endmodule : hwe_sync

`default_nettype wire

// [hw/hwe_ring_det.sv]
/*
 * ring detector: a fall followed by a rise of an active-low ring input
 * gives a one-cycle event pulse. one lane per input.
 * assumes the inputs are already synchronised to CLOCK.
 */
`default_nettype none

module hwe_ring_det #(
	parameter int N = 3 // number of ring inputs
) (
	input  wire logic         CLOCK, // block clock
	input  wire logic         NRST,  // synchronous reset, low
	input  wire logic [N-1:0] LVL_N, // synchronised ring levels
	output logic      [N-1:0] EVT    // ring completed, pulse
);
	////////////////////////////////////////////////////////////////
	// one detector per lane
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_lane
			logic prev_reg;  // level one cycle ago
			logic armed_reg; // fall seen, waiting for the rise
			// fall arms, rise fires; reset idles high so nothing arms
			always_ff @(posedge CLOCK) begin
				if (!NRST) begin
					prev_reg  <= 1'b1;
					armed_reg <= 1'b0;
					EVT[i]    <= 1'b0;
				end else begin
					prev_reg <= LVL_N[i];
					EVT[i]   <= armed_reg & ~prev_reg & LVL_N[i];
					if (prev_reg && !LVL_N[i]) begin
						armed_reg <= 1'b1;
					end else if (!prev_reg && LVL_N[i]) begin
						armed_reg <= 1'b0;
					end
				end
			end
		end
	endgenerate
endmodule : hwe_ring_det

`default_nettype wire

// [hw/hwe_wake_regs.sv]
/*
 * host-view wake event registers with their LPC I/O target: event
 * status and enable, signal monitor, sleep request and smi/irq routing,
 * plus the wake request, smi and irq outputs they steer.
 * assumes LPC runs on CLOCK, the pnp config block supplies the selected
 * logical device and base writes, and NRST is the standby power-up reset.
 */
`default_nettype none

module hwe_wake_regs (
	input  wire logic        CLOCK,               // 10 MHz block and LPC clock
	input  wire logic        NRST,                // standby power-up reset, low
	input  wire logic        HOST_SW_RST,         // host-domain software reset
	input  wire logic        LFRAME_N,            // LPC frame, low
	input  wire logic [3:0]  LAD_IN,              // LPC nibble from the wire
	output logic      [3:0]  LAD_OUT,             // LPC nibble we drive
	output logic             LAD_OE_N,            // LPC drive enable, low
	input  wire logic [7:0]  LOGICAL_DEVICE_NUM,  // selected pnp device
	input  wire logic        PNP_BASE_WE,         // pnp base write strobe
	input  wire logic [15:0] PNP_BASE,            // pnp base address
	input  wire logic        MODULE_IRQ,          // selected device interrupt
	input  wire logic        MODULE_IRQ_WAKE_EN,  // its wake enable
	input  wire logic        MODEM_RING1_IN_N,    // first modem ring pin
	input  wire logic        MODEM_RING2_IN_N,    // second modem ring pin
	input  wire logic        PHONE_RING_IN_N,     // telephone ring pin
	input  wire logic        RING_DET_EN,         // ring detection mode
	input  wire logic        SW_EVENT_MODE_SEL,   // software event mode
	input  wire logic        EC_SW_EVT_CLR,       // firmware clears sw event
	input  wire logic        PM_CHAN1_SMI_LEVEL,  // pm channel 1 smi level
	input  wire logic        PM_CHAN2_SMI_LEVEL,  // pm channel 2 smi level
	input  wire logic        SMI_PIN_LEVEL,       // smi wire level, pin
	input  wire logic        WAKE_REQ_PIN_LEVEL,  // wake wire level, pin
	output logic             WAKE_REQUEST_N,      // wake request, low
	output logic             SYS_MGMT_IRQ_N,      // smi, low
	output logic             WAKE_IRQ,            // host irq request
	output logic      [7:0]  EC_EVT_SET,          // ec-view status set pulses
	output logic      [7:0]  ACPI_REQ             // sleep request to firmware
);
	hwe_pkg::hwe_lpc_state_t state_reg; // LPC sequencer state
	hwe_pkg::hwe_lpc_state_t state_next;
	logic [1:0]  cnt_reg;               // nibble counter
	logic [15:0] addr_reg;              // shifted I/O address
	logic [15:0] addr_next;             // address with current nibble
	logic [7:0]  wdata_reg;             // write data
	logic [7:0]  rdata_reg;             // read data latched at sync
	logic        is_wr_reg;             // cycle is a write
	logic [15:0] base_reg;              // decode base address
	logic        base_valid_reg;        // base has been programmed
	logic        hit;                   // address falls in our window
	logic        host_wr;               // write commits this cycle
	logic [4:0]  ofs;                   // offset of current access
	logic [7:0]  wr_bits;               // write data on a status write
	logic [7:0]  status_reg;            // wake_event_status
	logic [7:0]  status_next;
	logic [7:0]  enable_reg;            // wake_event_enable
	logic [7:0]  smi_en_reg;            // wake_smi_route_enable
	logic [7:0]  irq_en_reg;            // wake_irq_route_enable
	logic [7:0]  set_vec;               // hardware event set pulses
	logic        sw_set;                // ec-view sw event set
	logic        mod_prev_reg;          // module irq one cycle ago
	logic        wake_drv_reg;          // wake_req_driven_level
	logic        smi_drv_reg;           // wake_ctl_smi_level
	logic [2:0]  ring_n_sync;           // synchronised ring pins
	logic [2:0]  ring_evt;              // completed ring pulses
	logic [1:0]  lvl_sync;              // synchronised wire levels
	logic [7:0]  monitor;               // wake_signal_monitor view
	logic [7:0]  rd_mux;                // read value for ofs
	logic        soft_clr;              // either reset

	assign soft_clr = !NRST || HOST_SW_RST;

	////////////////////////////////////////////////////////////////
	// pin inputs cross into CLOCK before anything looks at them
	hwe_sync #(.W(3), .RST_VAL(3'h7)) u_ring_sync (
		.CLOCK (CLOCK),
		.NRST  (NRST),
		.D     ({PHONE_RING_IN_N, MODEM_RING2_IN_N, MODEM_RING1_IN_N}),
		.Q     (ring_n_sync)
	);
	hwe_sync #(.W(2), .RST_VAL(2'h3)) u_lvl_sync (
		.CLOCK (CLOCK),
		.NRST  (NRST),
		.D     ({WAKE_REQ_PIN_LEVEL, SMI_PIN_LEVEL}),
		.Q     (lvl_sync)
	);
	// lane 2 phone, lane 1 modem 2, lane 0 modem 1
	hwe_ring_det #(.N(3)) u_ring_det (
		.CLOCK (CLOCK),
		.NRST  (NRST),
		.LVL_N (ring_n_sync),
		.EVT   (ring_evt)
	);

	////////////////////////////////////////////////////////////////
	// base address is taken only while our logical device is selected
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			base_reg       <= '0;
			base_valid_reg <= 1'b0;
		end else if (PNP_BASE_WE && LOGICAL_DEVICE_NUM == hwe_pkg::LDN_WAKE) begin
			base_reg       <= PNP_BASE;
			base_valid_reg <= 1'b1;
		end
	end

	// window aligned to 32 bytes; low base bits are ignored
	assign addr_next = {addr_reg[11:0], LAD_IN};
	assign hit = base_valid_reg &&
		addr_next[15:hwe_pkg::OFS_W] == base_reg[15:hwe_pkg::OFS_W];

	////////////////////////////////////////////////////////////////
	// LPC I/O target sequencer; a low frame always restarts it
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hwe_pkg::ST_IDLE: begin
				state_next = hwe_pkg::ST_IDLE;
			end
			hwe_pkg::ST_CYC: begin
				if (LAD_IN[3:1] == hwe_pkg::LPC_IO_RD || LAD_IN[3:1] == hwe_pkg::LPC_IO_WR) begin
					state_next = hwe_pkg::ST_ADDR;
				end else begin
					state_next = hwe_pkg::ST_SKIP; // memory, dma: not ours
				end
			end
			hwe_pkg::ST_ADDR: begin
				if (cnt_reg == hwe_pkg::ADDR_LAST) begin
					if (!hit) begin
						state_next = hwe_pkg::ST_SKIP;
					end else if (is_wr_reg) begin
						state_next = hwe_pkg::ST_WDATA;
					end else begin
						state_next = hwe_pkg::ST_HTAR;
					end
				end
			end
			hwe_pkg::ST_WDATA: begin
				if (cnt_reg == hwe_pkg::PAIR_LAST) begin
					state_next = hwe_pkg::ST_HTAR;
				end
			end
			hwe_pkg::ST_HTAR: begin
				if (cnt_reg == hwe_pkg::PAIR_LAST) begin
					state_next = hwe_pkg::ST_SYNC;
				end
			end
			hwe_pkg::ST_SYNC: begin
				state_next = is_wr_reg ? hwe_pkg::ST_DTAR : hwe_pkg::ST_RDATA;
			end
			hwe_pkg::ST_RDATA: begin
				if (cnt_reg == hwe_pkg::PAIR_LAST) begin
					state_next = hwe_pkg::ST_DTAR;
				end
			end
			hwe_pkg::ST_DTAR: begin
				if (cnt_reg == hwe_pkg::PAIR_LAST) begin
					state_next = hwe_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = hwe_pkg::ST_SKIP;
			end
		endcase
		// abort or new start overrides everything
		if (!LFRAME_N) begin
			state_next = (LAD_IN == hwe_pkg::LPC_START) ? hwe_pkg::ST_CYC : hwe_pkg::ST_IDLE;
		end
	end

	// state, counter and captured fields
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			state_reg <= hwe_pkg::ST_IDLE;
			cnt_reg   <= '0;
			addr_reg  <= '0;
			wdata_reg <= '0;
			is_wr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= (state_next == state_reg) ? cnt_reg + 2'h1 : 2'h0;
			if (state_reg == hwe_pkg::ST_CYC) begin
				is_wr_reg <= LAD_IN[3:1] == hwe_pkg::LPC_IO_WR;
			end
			if (state_reg == hwe_pkg::ST_ADDR) begin
				addr_reg <= addr_next;
			end
			if (state_reg == hwe_pkg::ST_WDATA) begin
				wdata_reg <= {LAD_IN, wdata_reg[7:4]}; // low nibble first
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// the access happens in the sync cycle, reads and writes alike
	assign ofs     = addr_reg[hwe_pkg::OFS_W-1:0];
	assign host_wr = state_reg == hwe_pkg::ST_SYNC && is_wr_reg;
	assign wr_bits = (host_wr && ofs == hwe_pkg::OFS_STATUS) ? wdata_reg : 8'h00;

	// monitor shows live levels only, nothing stored
	always_comb begin
		monitor                       = hwe_pkg::READ_ZERO;
		monitor[hwe_pkg::MON_DRV]     = wake_drv_reg;
		monitor[hwe_pkg::MON_PIN]     = lvl_sync[1];
		monitor[hwe_pkg::MON_PM2]     = PM_CHAN2_SMI_LEVEL;
		monitor[hwe_pkg::MON_PM1]     = PM_CHAN1_SMI_LEVEL;
		monitor[hwe_pkg::MON_CTL_SMI] = smi_drv_reg;
		monitor[hwe_pkg::MON_SMI_PIN] = lvl_sync[0];
	end

	// read decode; the sleep request reads back as zero
	always_comb begin
		if (ofs == hwe_pkg::OFS_STATUS) begin
			rd_mux = status_reg & hwe_pkg::EVENT_MASK;
		end else if (ofs == hwe_pkg::OFS_ENABLE) begin
			rd_mux = enable_reg & hwe_pkg::EVENT_MASK;
		end else if (ofs == hwe_pkg::OFS_MONITOR) begin
			rd_mux = monitor;
		end else if (ofs == hwe_pkg::OFS_SMI_EN) begin
			rd_mux = smi_en_reg;
		end else if (ofs == hwe_pkg::OFS_IRQ_EN) begin
			rd_mux = irq_en_reg;
		end else begin
			rd_mux = hwe_pkg::READ_ZERO; // sleep request and holes
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			rdata_reg <= hwe_pkg::READ_ZERO;
		end else if (state_reg == hwe_pkg::ST_SYNC) begin
			rdata_reg <= rd_mux;
		end
	end

	// LAD drive: sync, read data, then our turnaround
	always_comb begin
		LAD_OUT  = hwe_pkg::LPC_TAR;
		LAD_OE_N = 1'b1;
		if (state_reg == hwe_pkg::ST_SYNC) begin
			LAD_OUT  = hwe_pkg::LPC_SYNC_OK;
			LAD_OE_N = 1'b0;
		end else if (state_reg == hwe_pkg::ST_RDATA) begin
			LAD_OUT  = cnt_reg[0] ? rdata_reg[7:4] : rdata_reg[3:0];
			LAD_OE_N = 1'b0;
		end else if (state_reg == hwe_pkg::ST_DTAR && cnt_reg == 2'h0) begin
			LAD_OE_N = 1'b0; // drive high once, then release
		end
	end

	////////////////////////////////////////////////////////////////
	// hardware event detection, independent of wake_event_enable; module and phone events have their own gates
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			mod_prev_reg <= 1'b0;
		end else begin
			mod_prev_reg <= MODULE_IRQ;
		end
	end

	always_comb begin
		set_vec                    = 8'h00;
		set_vec[hwe_pkg::BIT_MODULE] = MODULE_IRQ && !mod_prev_reg && MODULE_IRQ_WAKE_EN;
		set_vec[hwe_pkg::BIT_PHONE]  = ring_evt[2] && RING_DET_EN;
		set_vec[hwe_pkg::BIT_RING2]  = ring_evt[1];
		set_vec[hwe_pkg::BIT_RING1]  = ring_evt[0];
	end

	// status next value; a set in the clearing cycle wins
	always_comb begin
		status_next = ((status_reg & ~(wr_bits & hwe_pkg::HW_CLR_MASK)) | set_vec)
			& hwe_pkg::EVENT_MASK;
		sw_set = 1'b0;
		if (!SW_EVENT_MODE_SEL) begin
			// toggle; the ec view sees only the rising toggle
			status_next[hwe_pkg::BIT_SW] = status_reg[hwe_pkg::BIT_SW] ^ wr_bits[hwe_pkg::BIT_SW];
			sw_set = wr_bits[hwe_pkg::BIT_SW] && !status_reg[hwe_pkg::BIT_SW];
		end else begin
			sw_set = wr_bits[hwe_pkg::BIT_SW];
			status_next[hwe_pkg::BIT_SW] = sw_set ||
				(status_reg[hwe_pkg::BIT_SW] && !EC_SW_EVT_CLR);
		end
		if (!RING_DET_EN) begin
			status_next[hwe_pkg::BIT_PHONE] = 1'b0;
		end
	end

	// no host power input reaches these: only standby and soft reset clear
	always_ff @(posedge CLOCK) begin
		if (soft_clr) begin
			status_reg <= hwe_pkg::REG_RESET;
			EC_EVT_SET <= 8'h00;
		end else begin
			status_reg <= status_next;
			EC_EVT_SET <= set_vec | ({7'h00, sw_set} << hwe_pkg::BIT_SW);
		end
	end

	////////////////////////////////////////////////////////////////
	// enable and routing registers; monitor writes fall through
	always_ff @(posedge CLOCK) begin
		if (soft_clr) begin
			enable_reg <= hwe_pkg::REG_RESET;
			smi_en_reg <= hwe_pkg::REG_RESET;
			irq_en_reg <= hwe_pkg::REG_RESET;
			ACPI_REQ   <= hwe_pkg::REG_RESET;
		end else if (host_wr) begin
			if (ofs == hwe_pkg::OFS_ENABLE) begin
				enable_reg <= wdata_reg & hwe_pkg::EVENT_MASK;
			end else if (ofs == hwe_pkg::OFS_SMI_EN) begin
				smi_en_reg <= wdata_reg & hwe_pkg::ROUTE_MASK;
			end else if (ofs == hwe_pkg::OFS_IRQ_EN) begin
				irq_en_reg <= wdata_reg & hwe_pkg::ROUTE_MASK;
			end else if (ofs == hwe_pkg::OFS_ACPI) begin
				ACPI_REQ   <= wdata_reg & hwe_pkg::ACPI_MASK;
			end
			// monitor offset: no storage, write ignored
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs follow pending-and-enabled one cycle after the status
	always_ff @(posedge CLOCK) begin
		if (soft_clr) begin
			wake_drv_reg <= 1'b1;
			smi_drv_reg  <= 1'b1;
			WAKE_IRQ     <= 1'b0;
		end else begin
			wake_drv_reg <= ~|(status_reg & enable_reg);
			smi_drv_reg  <= ~|(status_reg & smi_en_reg);
			WAKE_IRQ     <= |(status_reg & irq_en_reg);
		end
	end

	assign WAKE_REQUEST_N = wake_drv_reg;
	assign SYS_MGMT_IRQ_N = smi_drv_reg;
endmodule : hwe_wake_regs

`default_nettype wire

// [tb/hwe_wake_props.sv]
/* wake register checker on the dut ports.
   assumes a bind from the bench top and one clock domain. */
`default_nettype none
module hwe_wake_props (
	input wire logic       CLOCK,              // clock
	input wire logic       NRST,               // reset, low
	input wire logic       HOST_SW_RST,        // soft reset
	input wire logic       LFRAME_N,           // frame, low
	input wire logic [3:0] LAD_OUT,            // our nibble
	input wire logic       LAD_OE_N,           // drive, low
	input wire logic       MODULE_IRQ,         // device irq
	input wire logic       MODULE_IRQ_WAKE_EN, // its wake enable
	input wire logic       RING_DET_EN,        // ring mode
	input wire logic       WAKE_REQUEST_N,     // wake, low
	input wire logic       SYS_MGMT_IRQ_N,     // smi, low
	input wire logic       WAKE_IRQ,           // irq
	input wire logic [7:0] EC_EVT_SET,         // set pulses
	input wire logic [7:0] ACPI_REQ            // sleep request
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	////////////////////////////////////////////////////////////////
	// reset itself is the antecedent here, so no disable
	reset_idle_a: assert property (disable iff (1'b0) !NRST |=> LAD_OE_N && WAKE_REQUEST_N)
		else $error("outputs busy after reset");
	soft_reset_a: assert property (HOST_SW_RST |=> WAKE_REQUEST_N && SYS_MGMT_IRQ_N && !WAKE_IRQ && ACPI_REQ == 8'h00)
		else $error("outputs busy after soft reset");
	acpi_bits_a: assert property ((ACPI_REQ & ~hwe_pkg::ACPI_MASK) == 8'h00)
		else $error("sleep request reserved bit set");
	evt_bits_a: assert property ((EC_EVT_SET & ~hwe_pkg::EVENT_MASK) == 8'h00)
		else $error("event on a reserved bit");
	irq_edge_a: assert property ($rose(MODULE_IRQ) && MODULE_IRQ_WAKE_EN |-> ##[1:3] EC_EVT_SET[7])
		else $error("module irq edge not recorded");
	irq_pulse_a: assert property (EC_EVT_SET[7] |=> !EC_EVT_SET[7])
		else $error("module event pulse too long");
	ring_off_a: assert property ((!RING_DET_EN)[*3] |-> !EC_EVT_SET[3])
		else $error("phone ring recorded while off");
	no_drive_a: assert property (!LFRAME_N |-> LAD_OE_N)
		else $error("lad driven during frame");
	// sync first, driven one more cycle, released within four cycles
	sync_first_a: assert property ($fell(LAD_OE_N) |-> LAD_OUT == 4'h0 ##1 !LAD_OE_N ##[1:3] LAD_OE_N)
		else $error("bad sync or drive length");
	tar_last_a: assert property ($rose(LAD_OE_N) |-> $past(LAD_OUT) == hwe_pkg::LPC_TAR)
		else $error("no turnaround before release");
endmodule : hwe_wake_props
`default_nettype wire

// [tb/hwe_host_bfm.sv]
/* host side lpc i/o master model with pull-ups on lad.
   assumes callers start each task just after a rising edge. */
`default_nettype none
module hwe_host_bfm (
	input  wire logic       CLOCK,    // lpc clock
	input  wire logic [3:0] LAD_OUT,  // device nibble
	input  wire logic       LAD_OE_N, // device drive, low
	output var  logic       LFRAME_N, // frame, low
	output wire logic [3:0] LAD_IN    // resolved wire
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] lad_h = 4'hF; // host nibble
	logic       oe_h  = 1'b0; // host drives lad
	initial LFRAME_N = 1'b1;
	// pull-ups: a released wire reads F, never the last nibble
	assign LAD_IN = !LAD_OE_N ? LAD_OUT : (oe_h ? lad_h : 4'hF);
	////////////////////////////////////////////////////////////////
	// one nibble, held a full cycle
	task automatic nib(input logic [3:0] v);
		lad_h = v;
		oe_h = 1'b1;
		@(posedge CLOCK);
		#10;
	endtask : nib
	// one i/o cycle at address a; ok low if the device never syncs
	task automatic io(input logic wr, input logic [15:0] a, inout logic [7:0] d, output logic ok);
		LFRAME_N = 1'b0;
		nib(hwe_pkg::LPC_START);
		LFRAME_N = 1'b1;
		nib({2'h0, wr, 1'b0});
		for (int i = 3; i >= 0; i--) nib(a[i*4+:4]);
		if (wr) begin
			nib(d[3:0]);
			nib(d[7:4]);
		end
		nib(hwe_pkg::LPC_TAR);
		oe_h = 1'b0;
		@(posedge CLOCK);
		#10;
		// bounded wait for sync
		for (int i = 0; i < 6 && LAD_OE_N; i++) begin
			@(posedge CLOCK);
			#10;
		end
		ok = !LAD_OE_N && LAD_IN == hwe_pkg::LPC_SYNC_OK;
		if (ok && !wr) begin
			@(posedge CLOCK);
			#10 d[3:0] = LAD_IN;
			@(posedge CLOCK);
			#10 d[7:4] = LAD_IN;
		end
		repeat (2) @(posedge CLOCK);
		#10;
	endtask : io
endmodule : hwe_host_bfm
`default_nettype wire

// [tb/tb_host_wake_event_registers.sv]
/* self-checking bench for the host wake event registers.
   assumes the dut, its package, the checker and host model compile first. */
`default_nettype none
module tb_host_wake_event_registers;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] B = 16'h0A40; // window base
	logic CLOCK, NRST, HOST_SW_RST, PNP_BASE_WE, MODULE_IRQ, MODULE_IRQ_WAKE_EN, EC_SW_EVT_CLR;
	logic RING_DET_EN, SW_EVENT_MODE_SEL, PM_CHAN1_SMI_LEVEL, PM_CHAN2_SMI_LEVEL;
	logic LFRAME_N, LAD_OE_N, WAKE_REQUEST_N, SYS_MGMT_IRQ_N, WAKE_IRQ, ok;
	logic [3:0] LAD_IN, LAD_OUT;
	logic [7:0] LOGICAL_DEVICE_NUM, EC_EVT_SET, ACPI_REQ, d;
	logic [15:0] PNP_BASE;
	logic [2:0] rn = 3'h7; // ring pins, idle high
	logic [7:0] bm [3] = '{8'h01, 8'h02, 8'h08}; // ring status bits
	wire MODEM_RING1_IN_N = rn[0];
	wire MODEM_RING2_IN_N = rn[1];
	wire PHONE_RING_IN_N = rn[2];
	logic ext_smi_n = 1'b1;  // outside source on the smi wire
	logic ext_wake_n = 1'b1; // outside source on the wake wire
	wire SMI_PIN_LEVEL = SYS_MGMT_IRQ_N & ext_smi_n; // wired-and with an outside source
	wire WAKE_REQ_PIN_LEVEL = WAKE_REQUEST_N & ext_wake_n;
	int bad_count = 0;
	int check_count = 0;
	hwe_wake_regs i_dut (.CLOCK, .NRST, .HOST_SW_RST, .LFRAME_N, .LAD_IN, .LAD_OUT, .LAD_OE_N,
		.LOGICAL_DEVICE_NUM, .PNP_BASE_WE, .PNP_BASE, .MODULE_IRQ, .MODULE_IRQ_WAKE_EN,
		.MODEM_RING1_IN_N, .MODEM_RING2_IN_N, .PHONE_RING_IN_N, .RING_DET_EN, .SW_EVENT_MODE_SEL,
		.EC_SW_EVT_CLR, .PM_CHAN1_SMI_LEVEL, .PM_CHAN2_SMI_LEVEL, .SMI_PIN_LEVEL,
		.WAKE_REQ_PIN_LEVEL, .WAKE_REQUEST_N, .SYS_MGMT_IRQ_N, .WAKE_IRQ, .EC_EVT_SET, .ACPI_REQ);
	hwe_host_bfm i_host (.CLOCK, .LAD_OUT, .LAD_OE_N, .LFRAME_N, .LAD_IN);
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge CLOCK);
		#10;
	endtask : cyc
	task automatic wr(input logic [7:0] o, input logic [7:0] v);
		i_host.io(1'b1, B + 16'(o), v, ok);
		chk({7'h0, ok}, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] o, input logic [7:0] e);
		i_host.io(1'b0, B + 16'(o), d, ok);
		chk({7'h0, ok}, 8'h01);
		chk(d, e);
	endtask : rd
	// pin low a while, then high: one completed ring
	task automatic ring(input int k);
		rn[k] = 1'b0;
		cyc(4);
		rn[k] = 1'b1;
		cyc(8);
	endtask : ring
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////
	initial begin
		{NRST, HOST_SW_RST, PNP_BASE_WE, MODULE_IRQ, MODULE_IRQ_WAKE_EN, EC_SW_EVT_CLR} = 6'h00;
		{RING_DET_EN, SW_EVENT_MODE_SEL, PM_CHAN1_SMI_LEVEL, PM_CHAN2_SMI_LEVEL} = 4'h8;
		LOGICAL_DEVICE_NUM = 8'h05;
		PNP_BASE = 16'h0B00;
		cyc(2);
		NRST = 1'b1;
		PNP_BASE_WE = 1'b1; // other device: base must be ignored
		cyc(1);
		PNP_BASE_WE = 1'b0;
		i_host.io(1'b0, 16'h0B00, d, ok);
		chk({7'h0, ok}, 8'h00);
		LOGICAL_DEVICE_NUM = 8'h04;
		PNP_BASE = B;
		PNP_BASE_WE = 1'b1;
		cyc(1);
		PNP_BASE_WE = 1'b0;
		i_host.io(1'b0, B + 16'h0020, d, ok);
		chk({7'h0, ok}, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h06, 8'h00);
		rd(8'h06, 8'h33);
		PM_CHAN2_SMI_LEVEL = 1'b1;
		rd(8'h06, 8'h3B);
		{PM_CHAN2_SMI_LEVEL, PM_CHAN1_SMI_LEVEL} = 2'b01;
		rd(8'h06, 8'h37);
		PM_CHAN1_SMI_LEVEL = 1'b0;
		{ext_wake_n, ext_smi_n} = 2'b00; // another source pulls both wires low
		rd(8'h06, 8'h22);
		{ext_wake_n, ext_smi_n} = 2'b11;
		wr(8'h02, 8'hFF);
		rd(8'h02, 8'hCB);
		wr(8'h02, 8'h00);
		// each ring recorded while disabled, then gated onto wake
		for (int k = 0; k < 3; k++) begin
			ring(k);
			rd(8'h00, bm[k]);
			chk({7'h0, WAKE_REQUEST_N}, 8'h01);
			wr(8'h02, bm[k]);
			cyc(2);
			chk({7'h0, WAKE_REQUEST_N}, 8'h00);
			rd(8'h06, 8'h03);
			wr(8'h00, bm[k]);
			rd(8'h00, 8'h00);
			chk({7'h0, WAKE_REQUEST_N}, 8'h01);
			wr(8'h02, 8'h00);
		end
		RING_DET_EN = 1'b0;
		ring(2);
		rd(8'h00, 8'h00);
		for (int k = 1; k >= 0; k--) begin
			MODULE_IRQ_WAKE_EN = k[0];
			MODULE_IRQ = 1'b1;
			cyc(3);
			MODULE_IRQ = 1'b0;
			rd(8'h00, {k[0], 7'h00});
			wr(8'h00, 8'h80);
		end
		wr(8'h00, 8'h40);
		rd(8'h00, 8'h40);
		wr(8'h00, 8'h40);
		rd(8'h00, 8'h00);
		SW_EVENT_MODE_SEL = 1'b1;
		wr(8'h00, 8'h40);
		wr(8'h00, 8'h40);
		rd(8'h00, 8'h40);
		EC_SW_EVT_CLR = 1'b1;
		cyc(1);
		EC_SW_EVT_CLR = 1'b0;
		rd(8'h00, 8'h00);
		wr(8'h13, 8'hFF);
		rd(8'h13, 8'hCB);
		wr(8'h15, 8'hFF);
		rd(8'h15, 8'hCB);
		wr(8'h07, 8'hFF);
		rd(8'h07, 8'h00);
		chk(ACPI_REQ, 8'h3E);
		wr(8'h02, 8'h40);
		wr(8'h00, 8'h40);
		chk({5'h0, WAKE_REQUEST_N, SYS_MGMT_IRQ_N, WAKE_IRQ}, 8'h01);
		rd(8'h06, 8'h00);
		HOST_SW_RST = 1'b1;
		cyc(1);
		HOST_SW_RST = 1'b0;
		rd(8'h00, 8'h00);
		rd(8'h02, 8'h00);
		chk({5'h0, WAKE_REQUEST_N, SYS_MGMT_IRQ_N, WAKE_IRQ}, 8'h06);
		end_sim();
	end
endmodule : tb_host_wake_event_registers
bind hwe_wake_regs hwe_wake_props i_props (.CLOCK, .NRST, .HOST_SW_RST, .LFRAME_N, .LAD_OUT,
	.LAD_OE_N, .MODULE_IRQ, .MODULE_IRQ_WAKE_EN, .RING_DET_EN, .WAKE_REQUEST_N,
	.SYS_MGMT_IRQ_N, .WAKE_IRQ, .EC_EVT_SET, .ACPI_REQ);
`default_nettype wire
